// >>> design/pctd_regs.sv
// Compliance test selection and DSP tuning register bank of the PHY
//
// How it works
// - Bit 4 of 0x0027 enables 10 Mb/s patterns; clear means none driven.
// - Bit 4 of 0x0428 enables the 100 Mb/s transmit test modes.
// - 10 Mb/s codes 0-5: link pulse, one, zero, ones, zeros, preamble.
// - Codes 6-13: one/zero then idle, 1001 repeat, random, four idle variants.
// - 100 Mb/s zero count is {0x0428[5], 0x0027[3:0]}, 1 to 31.
// - All-zero 100 Mb/s value clears the pattern shift register.
// - 0x123 holds the 15-bit convergence error threshold, reset 0x51c.
// - 0x130 holds recal timer select, recal enable and step select.
// - 0x130 holds energy-lost trigger and clear selects, both reset one.
`timescale 1ns/10ps
module pctd_regs
   import pctd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input pctd_pkg::pctd_req_type req,
   output logic [15:0] rdata,
   output logic rvalid,
   output logic hit,
   output pctd_pkg::pctd_cfg_type cfg
);
   import pctd_pkg::*;

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [15:0] compliance_test_q;
   logic [15:0] tx100_ctrl_q;
   logic [15:0] energy_watchdog_q;
   logic [15:0] energy_window_q;
   logic [15:0] mse_threshold_q;
   logic [15:0] retrain_gain_q;
   logic [15:0] rdata_d;
   logic hit_d;
   pctd_cfg_type cfg_d;
   logic [4:0] tx100_value;

   // ----------------------------------------
   // Register words; each one masks its own reserved bits
   // ----------------------------------------
   // A read in the same cycle as a write still sees the old word,
   // because every word only changes at the write edge
   // Compliance test word: 10 Mb/s enable and test select
   pctd_field_reg #(
      .ADDR(ADDR_COMPLIANCE_TEST),
      .RESET_VALUE(RST_COMPLIANCE_TEST),
      .WRITE_MASK(MASK_COMPLIANCE_TEST)
   ) u_compliance_test (
      .clk(clk),
      .reset_n(reset_n),
      .req(req),
      .value_q(compliance_test_q)
   );

   // 100 Mb/s test word: enable and top bit of the zero count
   pctd_field_reg #(
      .ADDR(ADDR_TX100_TEST_CTRL),
      .RESET_VALUE(RST_TX100_TEST_CTRL),
      .WRITE_MASK(MASK_TX100_TEST_CTRL)
   ) u_tx100_ctrl (
      .clk(clk),
      .reset_n(reset_n),
      .req(req),
      .value_q(tx100_ctrl_q)
   );

   // Energy threshold and watchdog word
   pctd_field_reg #(
      .ADDR(ADDR_ENERGY_WATCHDOG),
      .RESET_VALUE(RST_ENERGY_WATCHDOG),
      .WRITE_MASK(MASK_ENERGY_WATCHDOG)
   ) u_energy_watchdog (
      .clk(clk),
      .reset_n(reset_n),
      .req(req),
      .value_q(energy_watchdog_q)
   );

   // Energy window and presence threshold word
   pctd_field_reg #(
      .ADDR(ADDR_ENERGY_WINDOW),
      .RESET_VALUE(RST_ENERGY_WINDOW),
      .WRITE_MASK(MASK_ENERGY_WINDOW)
   ) u_energy_window (
      .clk(clk),
      .reset_n(reset_n),
      .req(req),
      .value_q(energy_window_q)
   );

   // Convergence error threshold word
   pctd_field_reg #(
      .ADDR(ADDR_MSE_THRESHOLD),
      .RESET_VALUE(RST_MSE_THRESHOLD),
      .WRITE_MASK(MASK_MSE_THRESHOLD)
   ) u_mse_threshold (
      .clk(clk),
      .reset_n(reset_n),
      .req(req),
      .value_q(mse_threshold_q)
   );

   // Gain recalibration, energy-lost and sequencer watchdog word
   pctd_field_reg #(
      .ADDR(ADDR_RETRAIN_GAIN),
      .RESET_VALUE(RST_RETRAIN_GAIN),
      .WRITE_MASK(MASK_RETRAIN_GAIN)
   ) u_retrain_gain (
      .clk(clk),
      .reset_n(reset_n),
      .req(req),
      .value_q(retrain_gain_q)
   );

   // Read decode; unmapped addresses read zero and clear hit
   always_comb begin
      rdata_d = 16'h0000;
      hit_d = 1'b1;
      unique case (req.addr)
         ADDR_COMPLIANCE_TEST: rdata_d = compliance_test_q;
         ADDR_TX100_TEST_CTRL: rdata_d = tx100_ctrl_q;
         ADDR_ENERGY_WATCHDOG: rdata_d = energy_watchdog_q;
         ADDR_ENERGY_WINDOW: rdata_d = energy_window_q;
         ADDR_MSE_THRESHOLD: rdata_d = mse_threshold_q;
         ADDR_RETRAIN_GAIN: rdata_d = retrain_gain_q;
         default: hit_d = 1'b0;
      endcase
   end

   // Read answer registered one cycle after the request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 16'h0000;
         rvalid <= 1'b0;
         hit <= 1'b0;
      end else begin
         rvalid <= req.read_en;
         hit <= (req.read_en || req.write_en) && hit_d;
         if (req.read_en) begin
            rdata <= rdata_d;
         end
      end
   end

   // ----------------------------------------
   // Test mode and DSP field decode
   // ----------------------------------------
   assign tx100_value = {tx100_ctrl_q[TX100_MSB_BIT], compliance_test_q[3:0]};

   always_comb begin
      cfg_d = '0;
      cfg_d.test10_active = compliance_test_q[TEST_ENABLE_BIT];
      // Codes above 13 have no pattern, so nothing is driven
      if (compliance_test_q[TEST_ENABLE_BIT] && compliance_test_q[3:0] <= PCTD_PAT_IDLE_11) begin
         cfg_d.test10_pattern = pctd_pattern_type'(compliance_test_q[3:0]);
      end else begin
         cfg_d.test10_pattern = PCTD_PAT_NONE;
         cfg_d.test10_active = 1'b0;
      end
      cfg_d.test100_active = tx100_ctrl_q[TEST_ENABLE_BIT];
      cfg_d.test100_clear_shift = tx100_ctrl_q[TEST_ENABLE_BIT] && (tx100_value == 5'h00);
      cfg_d.test100_zero_count = tx100_ctrl_q[TEST_ENABLE_BIT] ? tx100_value : 5'h00;
      cfg_d.energy_loss_threshold = energy_watchdog_q[15:8];
      cfg_d.dfe_freeze = energy_watchdog_q[7];
      cfg_d.seq_watchdog_off = energy_watchdog_q[4];
      cfg_d.bad_mse_timer_select = energy_watchdog_q[3:1];
      cfg_d.energy_detect_int_only = energy_watchdog_q[0];
      cfg_d.energy_window_length = energy_window_q[15:8];
      cfg_d.energy_present_threshold = energy_window_q[7:0];
      cfg_d.convergence_error_threshold = mse_threshold_q[14:0];
      cfg_d.recal_timer_select = retrain_gain_q[14:12];
      cfg_d.recal_enable = retrain_gain_q[RECAL_ENABLE_BIT];
      cfg_d.recal_step_select = retrain_gain_q[RECAL_STEP_BIT];
      cfg_d.energy_lost_trigger_select = retrain_gain_q[ENERGY_LOST_TRIG_BIT];
      cfg_d.energy_lost_clear_select = retrain_gain_q[ENERGY_LOST_CLR_BIT];
      cfg_d.sequencer_watchdog_count_select = retrain_gain_q[7:0];
   end

   // Configuration outputs come from flip-flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg <= '0;
      end else begin
         cfg <= cfg_d;
      end
   end
endmodule

// ----------------------------------------
// One management register word
// ----------------------------------------
module pctd_field_reg
   import pctd_pkg::*;
#(
   parameter logic [15:0] ADDR = 16'h0000,
   parameter logic [15:0] RESET_VALUE = 16'h0000,
   parameter logic [15:0] WRITE_MASK = 16'hffff
)
(
   input wire logic clk,
   input wire logic reset_n,
   input pctd_pkg::pctd_req_type req,
   output logic [15:0] value_q
);
   import pctd_pkg::*;

   // Masked write: reserved bits never take a one, so they keep reading zero
   // Writes to any other address leave the word alone
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         value_q <= RESET_VALUE;
      end else if (req.write_en && (req.addr == ADDR)) begin
         value_q <= req.wdata & WRITE_MASK;
      end
   end
endmodule

// >>> design/pctd_pkg.sv
// Package: register map, field layout and reset values of the compliance test and DSP tuning registers
package pctd_pkg;
   // ----------------------------------------
   // Register addresses (management space)
   // ----------------------------------------
   localparam logic [15:0] ADDR_COMPLIANCE_TEST = 16'h0027;
   localparam logic [15:0] ADDR_TX100_TEST_CTRL = 16'h0428;
   localparam logic [15:0] ADDR_ENERGY_WATCHDOG = 16'h0101;
   localparam logic [15:0] ADDR_ENERGY_WINDOW = 16'h010a;
   localparam logic [15:0] ADDR_MSE_THRESHOLD = 16'h0123;
   localparam logic [15:0] ADDR_RETRAIN_GAIN = 16'h0130;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] RST_COMPLIANCE_TEST = 16'h0000;
   localparam logic [15:0] RST_TX100_TEST_CTRL = 16'h0000;
   localparam logic [15:0] RST_ENERGY_WATCHDOG = 16'h2082;
   localparam logic [15:0] RST_ENERGY_WINDOW = 16'h2040;
   localparam logic [15:0] RST_MSE_THRESHOLD = 16'h051c;
   localparam logic [15:0] RST_RETRAIN_GAIN = 16'h4f28;

   // ----------------------------------------
   // Writable bit masks (reserved bits cleared)
   // ----------------------------------------
   localparam logic [15:0] MASK_COMPLIANCE_TEST = 16'h001f;
   localparam logic [15:0] MASK_TX100_TEST_CTRL = 16'h0030;
   localparam logic [15:0] MASK_ENERGY_WATCHDOG = 16'hff9f;
   localparam logic [15:0] MASK_ENERGY_WINDOW = 16'hffff;
   localparam logic [15:0] MASK_MSE_THRESHOLD = 16'h7fff;
   localparam logic [15:0] MASK_RETRAIN_GAIN = 16'h7fff;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int TEST_ENABLE_BIT = 4;
   localparam int TX100_MSB_BIT = 5;
   localparam int RECAL_ENABLE_BIT = 11;
   localparam int RECAL_STEP_BIT = 10;
   localparam int ENERGY_LOST_TRIG_BIT = 9;
   localparam int ENERGY_LOST_CLR_BIT = 8;

   // 10 Mb/s test pattern codes
   typedef enum logic [3:0] {
      PCTD_PAT_LINK_PULSE = 4'h0,
      PCTD_PAT_ONE_PULSE = 4'h1,
      PCTD_PAT_ZERO_PULSE = 4'h2,
      PCTD_PAT_REP_ONES = 4'h3,
      PCTD_PAT_REP_ZEROS = 4'h4,
      PCTD_PAT_PREAMBLE = 4'h5,
      PCTD_PAT_ONE_IDLE = 4'h6,
      PCTD_PAT_ZERO_IDLE = 4'h7,
      PCTD_PAT_REP_1001 = 4'h8,
      PCTD_PAT_RANDOM = 4'h9,
      PCTD_PAT_IDLE_00 = 4'ha,
      PCTD_PAT_IDLE_01 = 4'hb,
      PCTD_PAT_IDLE_10 = 4'hc,
      PCTD_PAT_IDLE_11 = 4'hd,
      PCTD_PAT_NONE = 4'hf
   } pctd_pattern_type;

   // Management register access request
   typedef struct packed {
      logic read_en;
      logic write_en;
      logic [15:0] addr;
      logic [15:0] wdata;
   } pctd_req_type;

   // Configuration handed to the transmit test and DSP logic
   typedef struct packed {
      logic test10_active;
      pctd_pattern_type test10_pattern;
      logic test100_active;
      logic test100_clear_shift;
      logic [4:0] test100_zero_count;
      logic [7:0] energy_loss_threshold;
      logic dfe_freeze;
      logic seq_watchdog_off;
      logic [2:0] bad_mse_timer_select;
      logic energy_detect_int_only;
      logic [7:0] energy_window_length;
      logic [7:0] energy_present_threshold;
      logic [14:0] convergence_error_threshold;
      logic [2:0] recal_timer_select;
      logic recal_enable;
      logic recal_step_select;
      logic energy_lost_trigger_select;
      logic energy_lost_clear_select;
      logic [7:0] sequencer_watchdog_count_select;
   } pctd_cfg_type;
endpackage

// >>> verif/pctd_regs_props.sv
// Port checker of the compliance test and DSP tuning register bank
`timescale 1ns/10ps
module pctd_regs_chk
   import pctd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input pctd_pkg::pctd_req_type req,
   input wire logic [15:0] rdata,
   input wire logic rvalid,
   input wire logic hit,
   input pctd_pkg::pctd_cfg_type cfg
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Write strobes of the four checked registers
   logic w27, w428, w123, w130;
   assign w27 = req.write_en && req.addr == ADDR_COMPLIANCE_TEST;
   assign w428 = req.write_en && req.addr == ADDR_TX100_TEST_CTRL;
   assign w123 = req.write_en && req.addr == ADDR_MSE_THRESHOLD;
   assign w130 = req.write_en && req.addr == ADDR_RETRAIN_GAIN;
   chk_test10_off: assert property (w27 && !req.wdata[4] |=> ##1 cfg.test10_pattern == PCTD_PAT_NONE)
      else $error("10M pattern while off");
   chk_test10_code: assert property (w27 && req.wdata[4] && req.wdata[3:0] <= 4'hd |=> ##1
      cfg.test10_active && cfg.test10_pattern == $past(req.wdata[3:0], 2)) else $error("10M code");
   chk_test10_unused: assert property (w27 && req.wdata[4] && req.wdata[3:0] > 4'hd |=> ##1
      !cfg.test10_active && cfg.test10_pattern == PCTD_PAT_NONE) else $error("10M unused code");
   chk_test100_off: assert property (w428 && !req.wdata[4] |=> ##1
      !cfg.test100_active && cfg.test100_zero_count == 5'h0) else $error("100M on while off");
   chk_zero_count: assert property (w27 |=> ##1 (cfg.test100_active |->
      cfg.test100_zero_count[3:0] == $past(req.wdata[3:0], 2))) else $error("100M count");
   chk_clear_shift: assert property (cfg.test100_clear_shift |->
      cfg.test100_active && cfg.test100_zero_count == 5'h0) else $error("clear without zero");
   chk_mse_copy: assert property (w123 |=> ##1 cfg.convergence_error_threshold == $past(req.wdata[14:0], 2))
      else $error("threshold copy");
   chk_recal_copy: assert property (w130 |=> ##1
      {cfg.recal_timer_select, cfg.recal_enable, cfg.recal_step_select, cfg.energy_lost_trigger_select,
      cfg.energy_lost_clear_select} == $past(req.wdata[14:8], 2)) else $error("recal copy");
   chk_read_answer: assert property (req.read_en && req.addr == ADDR_MSE_THRESHOLD |=>
      rvalid && hit && !rdata[15]) else $error("read answer");
   chk_unmapped_read: assert property (req.read_en && req.addr == 16'h0000 |=>
      rvalid && !hit && rdata == 16'h0000) else $error("unmapped read");
   cover property (w27 && req.wdata[4]);
   cover property (w428 && req.wdata[4]);
   cover property (cfg.test100_clear_shift);
   cover property (rvalid && !hit);
endmodule
bind pctd_regs pctd_regs_chk u_chk (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata), .rvalid(rvalid),
   .hit(hit), .cfg(cfg));

// >>> verif/pctd_mgmt_model.sv
// Station management controller model issuing register requests
`timescale 1ns/10ps
module pctd_mgmt_model
   import pctd_pkg::*;
(
   input wire logic clk,
   output pctd_pkg::pctd_req_type req,
   input wire logic [15:0] rdata,
   input wire logic rvalid
);
   initial req = '0;
   // Release the bus: strobes low, address and data inverted
   task automatic park;
      @(negedge clk);
      req.read_en = 1'b0;
      req.write_en = 1'b0;
      req.addr = ~req.addr;
      req.wdata = ~req.wdata;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      req.write_en = 1'b1;
      req.addr = a;
      req.wdata = d;
      park();
   endtask
   // Answer is taken at the falling edge half a cycle after the request edge
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge clk);
      req.read_en = 1'b1;
      req.addr = a;
      park();
      d = rvalid ? rdata : 16'hxxxx;
   endtask
   // Force speed first, then disable, select, and re-enable the 100 Mb/s test
   task automatic set100(input logic [4:0] v);
      wr(16'h0000, 16'h2100);
      wr(ADDR_TX100_TEST_CTRL, 16'h0000);
      wr(ADDR_COMPLIANCE_TEST, {12'h000, v[3:0]});
      wr(ADDR_TX100_TEST_CTRL, {10'h000, v[4], 5'h10});
   endtask
endmodule

// >>> verif/tb_phy_compliance_test_dsp_cfg.sv
// Self-checking testbench of the compliance test and DSP tuning register bank
`timescale 1ns/10ps
module tb_phy_compliance_test_dsp_cfg;
   import pctd_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   pctd_req_type req;
   logic [15:0] rdata;
   logic rvalid;
   logic hit;
   pctd_cfg_type cfg;
   int errors = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [31:0] seed = 32'haee6c77c;
   logic [15:0] d;
   logic [4:0] v;
   logic [15:0] wv [6];
   logic [6:0] t100;
   logic [15:0] dsp_wd;
   logic [15:0] dsp_win;
   logic [15:0] dsp_mse;
   logic [15:0] dsp_rtg;
   logic [15:0] adr [6] = '{ADDR_COMPLIANCE_TEST, ADDR_TX100_TEST_CTRL, ADDR_ENERGY_WATCHDOG, ADDR_ENERGY_WINDOW,
      ADDR_MSE_THRESHOLD, ADDR_RETRAIN_GAIN};
   logic [15:0] rst [6] = '{16'h0000, 16'h0000, 16'h2082, 16'h2040, 16'h051c, 16'h4f28};
   logic [15:0] msk [6] = '{MASK_COMPLIANCE_TEST, MASK_TX100_TEST_CTRL, MASK_ENERGY_WATCHDOG, MASK_ENERGY_WINDOW,
      MASK_MSE_THRESHOLD, MASK_RETRAIN_GAIN};
   always #5 clk = ~clk;
   pctd_regs dut (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata), .rvalid(rvalid), .hit(hit), .cfg(cfg));
   pctd_mgmt_model m (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
   // Decoded fields packed back into register words for comparison
   assign t100 = {cfg.test100_active, cfg.test100_clear_shift, cfg.test100_zero_count};
   assign dsp_wd = {cfg.energy_loss_threshold, cfg.dfe_freeze, 2'b00, cfg.seq_watchdog_off, cfg.bad_mse_timer_select,
      cfg.energy_detect_int_only};
   assign dsp_win = {cfg.energy_window_length, cfg.energy_present_threshold};
   assign dsp_mse = {1'b0, cfg.convergence_error_threshold};
   assign dsp_rtg = {1'b0, cfg.recal_timer_select, cfg.recal_enable, cfg.recal_step_select,
      cfg.energy_lost_trigger_select, cfg.energy_lost_clear_select, cfg.sequencer_watchdog_count_select};
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected 10 Mb/s enable and code; unknown codes give no pattern
   function automatic logic [4:0] exp10(input logic [4:0] c);
      return (c[4] && c[3:0] <= 4'hd) ? c : 5'h0f;
   endfunction
   // Expected 100 Mb/s active, clear and zero count; a zero value clears the shift register
   function automatic logic [15:0] exp100(input logic [4:0] z);
      return (z == 5'h00) ? 16'h0060 : {9'h000, 2'b10, z};
   endfunction
   task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // DSP tuning fields against the last words written
   task automatic dsp_check;
      check("energy watchdog", dsp_wd, wv[2]);
      check("energy window", dsp_win, wv[3]);
      check("mse threshold", dsp_mse, wv[4]);
      check("retrain gain", dsp_rtg, wv[5]);
   endtask
   task automatic close_out;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      repeat (12) @(negedge clk);
      reset_n = 1'b1;
      wv = rst;
      for (int i = 0; i < 6; i++) begin
         m.rd(adr[i], d);
         check("reset", d, rst[i]);
         check("hit", {15'h0000, hit}, 16'h0001);
      end
      dsp_check();
      m.rd(16'h0000, d);
      check("unmapped", d, 16'h0000);
      check("unmapped hit", {15'h0000, hit}, 16'h0000);
      // Random words, reserved bits dropped
      repeat (8) begin
         for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            m.wr(adr[i], seed[15:0]);
            wv[i] = seed[15:0] & msk[i];
            m.rd(adr[i], d);
            check("readback", d, seed[15:0] & msk[i]);
         end
      end
      dsp_check();
      // Reset in mid-run brings every field back to its reset value
      @(negedge clk);
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      wv = rst;
      repeat (2) @(negedge clk);
      dsp_check();
      check("test10 reset", {cfg.test10_active, cfg.test10_pattern}, exp10(5'h00));
      check("test100 reset", {9'h000, t100}, 16'h0000);
      // Every 10 Mb/s code, enabled and disabled
      for (int c = 0; c < 32; c++) begin
         m.wr(ADDR_COMPLIANCE_TEST, 16'(c));
         repeat (2) @(negedge clk);
         check("test10", {cfg.test10_active, cfg.test10_pattern}, exp10(5'(c)));
      end
      // 100 Mb/s counts: zero, ends, random
      for (int k = 0; k < 12; k++) begin
         seed = lfsr(seed);
         v = (k == 0) ? 5'h00 : (k == 1) ? 5'h01 : (k == 2) ? 5'h1f : seed[4:0];
         m.set100(v);
         repeat (2) @(negedge clk);
         check("test100", {9'h000, t100}, exp100(v));
      end
      close_out();
   end
endmodule
